/* File: rtl/eiop_pin_cell.sv */
// One pin: drive, pull and function routing, registered outputs, input synchroniser
`timescale 1ns/1ps
module eiop_pin_cell (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Configuration of this pin
	input wire logic data_bit,
	input wire logic dir_bit,
	input wire logic [1:0] drive_code,
	input wire logic [1:0] func_code,
	// Peripheral side for the selected function
	input wire logic [3:1] func_out_avail,
	input wire logic [3:1] func_out_val,
	input wire logic [3:1] func_oe_val,
	// Pad
	input wire logic pad_in,
	output logic pad_out,
	output logic pad_oe,
	output logic pull_up_en,
	output logic pull_down_en,
	output logic pin_sync
);

	// ------------------------------------------------------------
	// Output value and enable
	// ------------------------------------------------------------
	logic [1:0] sync_q;
	logic pad_out_q;
	logic pad_oe_q;
	logic pu_q;
	logic pd_q;
	logic is_gpio;
	logic func_ok;
	logic src_val;
	logic src_oe;
	logic drv_high;
	logic drv_low;
	logic pad_out_d;
	logic pad_oe_d;

	assign is_gpio = (func_code == eiop_pkg::FUNC_GPIO);
	assign func_ok = !is_gpio && func_out_avail[func_code];
	// Peripheral may drive its own enable, e.g. bidirectional clock or data
	assign src_val = is_gpio ? data_bit : (func_ok ? func_out_val[func_code] : 1'b0);
	assign src_oe = is_gpio ? 1'b1 : (func_ok ? func_oe_val[func_code] : 1'b1);
	assign drv_high = (drive_code == eiop_pkg::DRV_PCH_OD) || (drive_code == eiop_pkg::DRV_CMOS);
	assign drv_low = (drive_code == eiop_pkg::DRV_NCH_OD) || (drive_code == eiop_pkg::DRV_CMOS);
	// Direction picks how the drive code is read
	assign pad_oe_d = !dir_bit && src_oe && (src_val ? drv_high : drv_low);
	assign pad_out_d = src_val;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pad_out_q <= 1'b0;
			pad_oe_q <= 1'b0;
			pu_q <= 1'b0;
			pd_q <= 1'b0;
			sync_q <= eiop_pkg::SYNC_RESET;
		end else begin
			pad_out_q <= pad_out_d;
			pad_oe_q <= pad_oe_d;
			pu_q <= dir_bit && (drive_code == eiop_pkg::PULL_UP);
			pd_q <= dir_bit && (drive_code == eiop_pkg::PULL_DOWN);
			sync_q <= {sync_q[0], pad_in};
		end
	end

	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign pull_up_en = pu_q;
	assign pull_down_en = pd_q;
	assign pin_sync = sync_q[1];

endmodule : eiop_pin_cell

/* File: rtl/eiop_pin_if.sv */
// Interface: configuration and data carried from the register file to the pin logic
`timescale 1ns/1ps
interface eiop_pin_if;
	logic [7:0] data_out;
	logic [7:0] dir_in;
	logic [7:0] drive_lo;
	logic [7:0] drive_hi;
	logic [7:0] func_lo;
	logic [7:0] func_hi;
	logic [7:0] pin_sync;

	modport regs (output data_out, dir_in, drive_lo, drive_hi, func_lo, func_hi, input pin_sync);
	modport pins (input data_out, dir_in, drive_lo, drive_hi, func_lo, func_hi, output pin_sync);
endinterface : eiop_pin_if

/* File: rtl/eiop_pkg.sv */
// Package: register map, codes and reset values of the eight-bit port
package eiop_pkg;

	// ------------------------------------------------------------
	// Register byte addresses (APB, byte addresses as printed)
	// ------------------------------------------------------------
	localparam logic [15:0] PIN_DATA_ADDR = 16'hf244;
	localparam logic [15:0] PIN_DIRECTION_ADDR = 16'hf245;
	localparam logic [15:0] DRIVE_SELECT_LOW_ADDR = 16'hf246;
	localparam logic [15:0] DRIVE_SELECT_HIGH_ADDR = 16'hf247;
	localparam logic [15:0] FUNCTION_SELECT_LOW_ADDR = 16'hf248;
	localparam logic [15:0] FUNCTION_SELECT_HIGH_ADDR = 16'hf249;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int PIN_COUNT = 8;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] SYNC_RESET = 2'h0;
	localparam logic [4:0] RX_IDLE = 5'h1f;

	// ------------------------------------------------------------
	// Per-pin codes
	// ------------------------------------------------------------
	localparam logic [1:0] DRV_HIZ = 2'h0;
	localparam logic [1:0] DRV_PCH_OD = 2'h1;
	localparam logic [1:0] DRV_NCH_OD = 2'h2;
	localparam logic [1:0] DRV_CMOS = 2'h3;
	localparam logic [1:0] PULL_NONE_A = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP = 2'h2;
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_SECOND = 2'h1;
	localparam logic [1:0] FUNC_THIRD = 2'h2;
	localparam logic [1:0] FUNC_FOURTH = 2'h3;

	typedef enum logic [1:0] {
		EIOP_IDLE,
		EIOP_ACCESS
	} eiop_state_t;

endpackage : eiop_pkg

/* File: rtl/eiop_port.sv */
// Top: eight-bit general-purpose port with APB register file
// Operation
// - Eight independent bidirectional pins, one bit per pin in every register.
// - Output pins are driven from the matching data register bit.
// - Written data reads back for pins configured as outputs.
// - Input pins read the sampled pin level instead of stored data.
// - Data bit 0 means low, 1 means high, both directions.
// - Direction 0 is output, 1 is input; resets to output.
// - Output drive codes: hi-z, P open drain, N open drain, CMOS.
// - Input codes: hi-z, pull-down, pull-up, hi-z.
// - All registers reset to zero: outputs, high impedance, data low.
// - Control bits are interpreted according to the current direction.
// - Data and direction byte only; control and function low accept halfwords.
// - Each pin can hand its paths to an on-chip peripheral function.
// - Function code 00 is plain port; other codes select peripherals.
// - Reserved function with output: hi-z or P gives hi-z, else low.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module eiop_port (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pads
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output logic [7:0] pull_up_en,
	output logic [7:0] pull_down_en,
	// Peripheral outputs toward the pins
	input wire logic pwm_out_a,
	input wire logic pwm_out_b,
	input wire logic uart_a_transmit,
	input wire logic uart_b_transmit,
	input wire logic sync_serial_out,
	input wire logic sync_serial_clock_out,
	input wire logic sync_serial_clock_oe,
	input wire logic i2c_clock_low,
	input wire logic i2c_data_low,
	// Pin levels toward the peripherals
	output logic uart_a_receive,
	output logic sync_serial_in,
	output logic sync_serial_clock,
	output logic i2c_clock_in,
	output logic i2c_data_in
);

	// ------------------------------------------------------------
	// Register state and bus handshake
	// ------------------------------------------------------------
	eiop_pin_if pif ();
	eiop_pkg::eiop_state_t state_q;
	logic [7:0] data_q;
	logic [7:0] dir_q;
	logic [7:0] drv_lo_q;
	logic [7:0] drv_hi_q;
	logic [7:0] fn_lo_q;
	logic [7:0] fn_hi_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [4:0] rx_q;

	// Byte lane within the bus word: lane = paddr[1:0]
	logic [1:0] lane;
	logic [7:0] wbyte;
	logic [7:0] wbyte_hi;
	logic sel_data;
	logic sel_dir;
	logic sel_dlo;
	logic sel_dhi;
	logic sel_flo;
	logic sel_fhi;
	logic is_half;
	logic is_byte;
	logic mapped;
	logic size_ok;
	logic access_ok;
	logic wr_ok;
	logic [7:0] data_rd;
	logic [7:0] rd_byte;
	logic [7:0] rd_byte_hi;
	logic [31:0] rd_pair;
	logic [31:0] rd_word;
	logic we_data;
	logic we_dir;
	logic we_dlo;
	logic we_dhi;
	logic we_flo;
	logic we_fhi;
	logic [7:0] drv_hi_d;
	logic [7:0] fn_hi_d;

	assign lane = paddr[1:0];
	// Byte lanes picked by pstrb; one set strobe is byte, two adjacent from an even lane is halfword
	assign is_byte = (pstrb == (4'h1 << lane));
	assign is_half = (pstrb == (4'h3 << lane)) && !lane[0];
	assign wbyte = pwdata[8 * lane +: 8];
	assign wbyte_hi = pwdata[8 * (lane + 2'd1) +: 8];
	assign sel_data = (paddr == eiop_pkg::PIN_DATA_ADDR);
	assign sel_dir = (paddr == eiop_pkg::PIN_DIRECTION_ADDR);
	assign sel_dlo = (paddr == eiop_pkg::DRIVE_SELECT_LOW_ADDR);
	assign sel_dhi = (paddr == eiop_pkg::DRIVE_SELECT_HIGH_ADDR);
	assign sel_flo = (paddr == eiop_pkg::FUNCTION_SELECT_LOW_ADDR);
	assign sel_fhi = (paddr == eiop_pkg::FUNCTION_SELECT_HIGH_ADDR);
	assign mapped = sel_data || sel_dir || sel_dlo || sel_dhi || sel_flo || sel_fhi;
	// Reads ignore pstrb (APB reads carry no strobes); writes need a legal size
	assign size_ok = is_byte || (is_half && (sel_dlo || sel_flo));
	assign access_ok = mapped && (!pwrite || size_ok);
	assign wr_ok = psel && penable && pwrite && access_ok && (state_q == eiop_pkg::EIOP_ACCESS);

	// Inputs read the synchronised pad; outputs read the stored value
	assign data_rd = (dir_q & pif.pin_sync) | (~dir_q & data_q);
	assign rd_byte = sel_data ? data_rd :
		sel_dir ? dir_q :
		sel_dlo ? drv_lo_q :
		sel_dhi ? drv_hi_q :
		sel_flo ? fn_lo_q :
		sel_fhi ? fn_hi_q : 8'h00;
	assign rd_byte_hi = sel_dlo ? drv_hi_q : (sel_flo ? fn_hi_q : 8'h00);
	// Lane placement; upper lanes read zero unless a halfword partner exists
	assign rd_pair = {16'h0000, rd_byte_hi, rd_byte};
	assign rd_word = rd_pair << (8 * lane);

	// ------------------------------------------------------------
	// Write decode: one enable per register
	// ------------------------------------------------------------
	assign we_data = wr_ok && sel_data;
	assign we_dir = wr_ok && sel_dir;
	assign we_dlo = wr_ok && sel_dlo;
	// A halfword at the low byte also lands in its high partner
	assign we_dhi = wr_ok && (sel_dhi || (sel_dlo && is_half));
	assign we_flo = wr_ok && sel_flo;
	assign we_fhi = wr_ok && (sel_fhi || (sel_flo && is_half));
	assign drv_hi_d = sel_dhi ? wbyte : wbyte_hi;
	assign fn_hi_d = sel_fhi ? wbyte : wbyte_hi;

	// ------------------------------------------------------------
	// APB state: one wait state, answer in the second access cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= eiop_pkg::EIOP_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			case (state_q)
				eiop_pkg::EIOP_IDLE: begin
					pready_q <= 1'b0;
					if (psel && penable && !pready_q) begin
						state_q <= eiop_pkg::EIOP_ACCESS;
						pready_q <= 1'b1;
						pslverr_q <= !access_ok;
						// Read data captured at the same edge that raises pready
						prdata_q <= (!pwrite && access_ok) ? rd_word : 32'h00000000;
					end
				end
				eiop_pkg::EIOP_ACCESS: begin
					state_q <= eiop_pkg::EIOP_IDLE;
					pready_q <= 1'b0;
					pslverr_q <= 1'b0;
				end
				default: begin
					state_q <= eiop_pkg::EIOP_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register writes at the completing edge
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_q <= eiop_pkg::REG_RESET;
			dir_q <= eiop_pkg::REG_RESET;
			drv_lo_q <= eiop_pkg::REG_RESET;
			drv_hi_q <= eiop_pkg::REG_RESET;
			fn_lo_q <= eiop_pkg::REG_RESET;
			fn_hi_q <= eiop_pkg::REG_RESET;
		end else begin
			if (we_data) data_q <= wbyte;
			if (we_dir) dir_q <= wbyte;
			if (we_dlo) drv_lo_q <= wbyte;
			if (we_dhi) drv_hi_q <= drv_hi_d;
			if (we_flo) fn_lo_q <= wbyte;
			if (we_fhi) fn_hi_q <= fn_hi_d;
		end
	end

	// ------------------------------------------------------------
	// Register file toward the pin logic
	// ------------------------------------------------------------
	assign pif.data_out = data_q;
	assign pif.dir_in = dir_q;
	assign pif.drive_lo = drv_lo_q;
	assign pif.drive_hi = drv_hi_q;
	assign pif.func_lo = fn_lo_q;
	assign pif.func_hi = fn_hi_q;

	// ------------------------------------------------------------
	// Function routing per pin (index = function code 1..3)
	// ------------------------------------------------------------
	logic [3:1] f_avail [8];
	logic [3:1] f_val [8];
	logic [3:1] f_oe [8];
	logic [7:0] sync_bits;

	// Input-only functions drive nothing: enable kept low. Open-drain I2C drives low only.
	assign f_avail[0] = 3'b011;
	assign f_val[0] = 3'b000;
	assign f_oe[0] = {1'b0, 1'b0, i2c_data_low};
	assign f_avail[1] = 3'b011;
	assign f_val[1] = {1'b0, sync_serial_clock_out, 1'b0};
	assign f_oe[1] = {1'b0, sync_serial_clock_oe, i2c_clock_low};
	assign f_avail[2] = 3'b011;
	assign f_val[2] = {1'b0, sync_serial_out, 1'b0};
	assign f_oe[2] = 3'b110;
	assign f_avail[3] = 3'b111;
	assign f_val[3] = {uart_b_transmit, pwm_out_a, uart_a_transmit};
	assign f_oe[3] = 3'b111;
	assign f_avail[4] = 3'b010;
	assign f_val[4] = 3'b000;
	assign f_oe[4] = 3'b000;
	assign f_avail[5] = 3'b010;
	assign f_val[5] = {1'b0, sync_serial_clock_out, 1'b0};
	assign f_oe[5] = {1'b0, sync_serial_clock_oe, 1'b0};
	assign f_avail[6] = 3'b010;
	assign f_val[6] = {1'b0, sync_serial_out, 1'b0};
	assign f_oe[6] = 3'b010;
	assign f_avail[7] = 3'b010;
	assign f_val[7] = {1'b0, pwm_out_b, 1'b0};
	assign f_oe[7] = 3'b010;

	genvar gi;
	generate
		for (gi = 0; gi < eiop_pkg::PIN_COUNT; gi++) begin : g_pin
			eiop_pin_cell u_cell (
				.clk(clk),
				.rst_b(rst_b),
				.data_bit(pif.data_out[gi]),
				.dir_bit(pif.dir_in[gi]),
				.drive_code({pif.drive_hi[gi], pif.drive_lo[gi]}),
				.func_code({pif.func_hi[gi], pif.func_lo[gi]}),
				.func_out_avail(f_avail[gi]),
				.func_out_val(f_val[gi]),
				.func_oe_val(f_oe[gi]),
				.pad_in(pad_in[gi]),
				.pad_out(pad_out[gi]),
				.pad_oe(pad_oe[gi]),
				.pull_up_en(pull_up_en[gi]),
				.pull_down_en(pull_down_en[gi]),
				.pin_sync(sync_bits[gi])
			);
		end
	endgenerate

	assign pif.pin_sync = sync_bits;

	// ------------------------------------------------------------
	// Peripheral inputs: pin level when that function is selected, else idle high
	// ------------------------------------------------------------
	logic [4:0] rx_d;

	assign rx_d[0] = ({fn_hi_q[2], fn_lo_q[2]} == eiop_pkg::FUNC_SECOND) ? sync_bits[2] : 1'b1;
	assign rx_d[1] = ({fn_hi_q[0], fn_lo_q[0]} == eiop_pkg::FUNC_THIRD) ? sync_bits[0] :
		(({fn_hi_q[4], fn_lo_q[4]} == eiop_pkg::FUNC_THIRD) ? sync_bits[4] : 1'b1);
	assign rx_d[2] = ({fn_hi_q[1], fn_lo_q[1]} == eiop_pkg::FUNC_THIRD) ? sync_bits[1] :
		(({fn_hi_q[5], fn_lo_q[5]} == eiop_pkg::FUNC_THIRD) ? sync_bits[5] : 1'b1);
	assign rx_d[3] = ({fn_hi_q[1], fn_lo_q[1]} == eiop_pkg::FUNC_SECOND) ? sync_bits[1] : 1'b1;
	assign rx_d[4] = ({fn_hi_q[0], fn_lo_q[0]} == eiop_pkg::FUNC_SECOND) ? sync_bits[0] : 1'b1;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_q <= eiop_pkg::RX_IDLE;
		end else begin
			rx_q <= rx_d;
		end
	end

	assign uart_a_receive = rx_q[0];
	assign sync_serial_in = rx_q[1];
	assign sync_serial_clock = rx_q[2];
	assign i2c_clock_in = rx_q[3];
	assign i2c_data_in = rx_q[4];
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

endmodule : eiop_port

/* File: verification/eiop_pads.sv */
// Partner: external pad network with forcing drivers, pulls and floating lines
`timescale 1ns/1ps
module eiop_pads (
	// Clock
	input wire logic clk,
	// Device pads
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en,
	// External drivers
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pad_in
);
	// Unpulled, undriven lines wander so a stale level never reads as valid
	logic [7:0] float_q = 8'h55;
	always @(posedge clk) float_q <= ~float_q;
	wire [7:0] drv = pad_oe | ext_en;
	wire [7:0] lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val);
	assign pad_in = (drv & lvl) | (~drv & (pull_up_en | (~pull_down_en & float_q)));
endmodule : eiop_pads

/* File: verification/eiop_port_tb_top.sv */
// Testbench: register, pin and function checks of the eight-bit port
`timescale 1ns/1ps
module eiop_port_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [7:0] pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, eo;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [8:0] per = 9'h1ff;
	logic [4:0] per_in;
	int fail_count = 0;
	int n_tests = 0;

	initial forever #2.5 clk = ~clk;

	eiop_port dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_down_en, .pwm_out_a(per[0]),
		.pwm_out_b(per[1]), .uart_a_transmit(per[2]), .uart_b_transmit(per[3]), .sync_serial_out(per[4]),
		.sync_serial_clock_out(per[5]), .sync_serial_clock_oe(per[6]), .i2c_clock_low(per[7]),
		.i2c_data_low(per[8]), .uart_a_receive(per_in[0]), .sync_serial_in(per_in[1]),
		.sync_serial_clock(per_in[2]), .i2c_clock_in(per_in[3]), .i2c_data_in(per_in[4]));
	eiop_pads u_pads (.clk, .pad_out, .pad_oe, .pull_up_en, .pull_down_en, .ext_en, .ext_val, .pad_in);

	// ----
	// Tasks
	// ----
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Entered just after a rising edge; holds the request until pready is sampled
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		chk("wait", 2, n);
	endtask : apb

	task automatic wr(input logic [15:0] a, input logic [7:0] b);
		apb(1'b1, a, {24'h0, b} << (8 * a[1:0]), 4'h1 << a[1:0]);
	endtask : wr

	task automatic hw(input logic [15:0] a, input logic [7:0] lo, input logic [7:0] hi);
		apb(1'b1, a, {16'h0000, hi, lo} << (8 * a[1:0]), 4'h3 << a[1:0]);
		chk("hw_err", 0, err);
	endtask : hw

	task automatic rdc(input string nm, input logic [15:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, exp, rd[8 * a[1:0] +: 8]);
		chk("rd_err", 0, err);
	endtask : rdc

	task automatic settle;
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic tally_and_finish;
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----
	// Sequence
	// ----
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		chk("oe_rst", 0, pad_oe);
		for (int i = 0; i < 6; i++) rdc("reset", 16'hf244 + 16'(i), 8'h00);
		for (int i = 1; i < 6; i++) wr(16'hf244 + 16'(i), 8'h5a + 8'(i));
		for (int i = 1; i < 6; i++) rdc("rw", 16'hf244 + 16'(i), 8'h5a + 8'(i));
		hw(16'hf248, 8'h00, 8'h00);
		hw(16'hf246, 8'hff, 8'hff);
		ext_en <= 8'hff;
		ext_val <= 8'h3c;
		wr(16'hf245, 8'h0f);
		wr(16'hf244, 8'h96);
		settle();
		rdc("mixed", 16'hf244, 8'h9c);
		chk("out_hi", 8'h90, pad_out & 8'hf0);
		wr(16'hf244, 8'h5a);
		ext_en <= 8'h00;
		for (int c = 0; c < 4; c++) begin
			eo = c == 0 ? 8'h00 : c == 1 ? 8'h5a : c == 2 ? 8'ha5 : 8'hff;
			hw(16'hf246, {8{c[0]}}, {8{c[1]}});
			wr(16'hf245, 8'h00);
			settle();
			chk("oe", eo, pad_oe);
			chk("lvl", 8'h5a & eo, pad_out & eo);
			wr(16'hf245, 8'hff);
			settle();
			chk("pu", c == 2 ? 8'hff : 8'h00, pull_up_en);
			chk("pd", c == 1 ? 8'hff : 8'h00, pull_down_en);
			chk("oe_in", 0, pad_oe);
			if (c == 1 || c == 2) rdc("pull", 16'hf244, c == 2 ? 8'hff : 8'h00);
		end
		wr(16'hf245, 8'h00);
		apb(1'b1, 16'hf244, 32'h0000ffff, 4'h3);
		chk("hw_data", 1, err);
		apb(1'b1, 16'hf245, 32'h00ffff00, 4'h6);
		chk("hw_dir", 1, err);
		apb(1'b0, 16'hf24c, 32'h0, 4'h0);
		chk("unmapped", 1, err);
		chk("unmapped_rd", 0, rd);
		rdc("kept", 16'hf244, 8'h5a);
		wr(16'hf244, 8'hff);
		hw(16'hf246, 8'hff, 8'hff);
		hw(16'hf248, 8'h88, 8'h00);
		per <= 9'h1fb;
		settle();
		chk("fn_out", 8'h77, pad_out);
		chk("fn_oe", 8'hff, pad_oe);
		hw(16'hf248, 8'h00, 8'h08);
		per <= 9'h1fe;
		settle();
		chk("pwm", 8'hf7, pad_out);
		hw(16'hf246, 8'hff, 8'h00);
		hw(16'hf248, 8'h80, 8'h00);
		settle();
		chk("rsv_p", 8'h7f, pad_oe);
		hw(16'hf248, 8'h04, 8'h00);
		wr(16'hf245, 8'h04);
		ext_en <= 8'h04;
		ext_val <= 8'h00;
		settle();
		chk("rx", 5'h1e, per_in);
		hw(16'hf248, 8'h00, 8'h00);
		settle();
		chk("rx_idle", 5'h1f, per_in);
		wr(16'hf245, 8'h00);
		hw(16'hf246, 8'h00, 8'h00);
		settle();
		chk("analog", 0, pad_oe);
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : eiop_port_tb_top

bind eiop_port eiop_sva u_sva (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pstrb, .pready, .pslverr,
	.pad_oe, .pull_up_en, .pull_down_en);

/* File: verification/eiop_sva.sv */
// Checker: APB handshake and pad/pull relations of the port
`timescale 1ns/1ps
module eiop_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	// Pads
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire mapped = paddr >= 16'hf244 && paddr <= 16'hf249;
	wire byte_only = paddr[15:1] == 15'h7922;

	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("answer not after one wait state");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_err_a: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	byte_size_a: assert property (pready && pwrite && byte_only && pstrb != (4'h1 << paddr[1:0]) |-> pslverr)
		else $error("wide write to byte register accepted");
	read_ok_a: assert property (pready && !pwrite && mapped |-> !pslverr)
		else $error("mapped read refused");
	pull_excl_a: assert property ((pull_up_en & pull_down_en) == 8'h00)
		else $error("both pulls on one pin");
	pull_drive_a: assert property ((pad_oe & (pull_up_en | pull_down_en)) == 8'h00)
		else $error("pull enabled on a driven pin");
	reset_idle_a: assert property ($rose(rst_b) |-> pad_oe == 8'h00 && pull_up_en == 8'h00)
		else $error("pins not idle after reset");
endmodule : eiop_sva
